// ---- design/sensor_cmd_handler.v ----
`include "sensor_cmd_map.vh"
`default_nettype none
// Command handler: commands arrive decoded from the line receiver
module sensor_cmd_handler (
   input  wire                 clock_i,
   input  wire                 resetn_i,
   // Decoded request from the line receiver
   input  wire                 req_valid_i,
   input  wire                 req_binary_i,
   input  wire [7:0]           req_addr_i,
   input  wire [7:0]           req_func_i,
   input  wire [3:0]           req_cmd_i,
   input  wire [15:0]          req_arg_i,
   // Raw converter result, calibration terms, digital inputs, filter time constants
   input  wire [15:0]          raw_sample_i,
   input  wire [15:0]          offset_err_i,
   input  wire [15:0]          gain_corr_i,
   input  wire [`DIO_W-1:0]    din_i,
   input  wire [3:0]           tc_small_i,
   input  wire [3:0]           tc_large_i,
   // Nonvolatile store image
   input  wire [7:0]           nv_addr_i,
   input  wire [15:0]          nv_cfg_i,
   input  wire                 nv_valid_i,
   output reg                  nv_write_o,
   output reg  [7:0]           nv_addr_o,
   output reg  [15:0]          nv_cfg_o,
   // Status and outputs
   output wire                 binary_mode_o,
   output reg                  conv_start_o,
   output reg  [15:0]          result_o,
   output reg  [`DIO_W-1:0]    dout_o,
   output reg                  restart_o,
   output wire                 tx_o,
   output wire                 tx_oe_n_o
);
   //-----------------------------------------
   // Conversion and filtering
   //-----------------------------------------
   localparam S_IDLE = 2'd0;
   localparam S_SEND = 2'd1;
   localparam S_WAIT = 2'd2;

   reg [31:0] conv_cnt_reg;
   reg [15:0] filt_reg;
   reg [15:0] zero_reg;
   reg [7:0]  addr_reg;
   reg [15:0] cfg_reg;
   reg        binary_reg;
   reg        wren_reg;
   reg [1:0]  state_reg;
   reg [2:0]  byte_cnt_reg;
   reg [7:0]  tx_byte_reg;
   reg [39:0] reply_reg;
   reg        send_reg;
   wire       framer_busy;
   wire [15:0] corrected;
   wire [15:0] delta;
   wire [3:0]  shift;
   wire        mine;
   wire        protected_cmd;

   // Pick time constant by change size
   function [3:0] pick_tc;
      input [15:0] d;
      input [3:0]  sm_tc;
      input [3:0]  lg_tc;
      begin
         pick_tc = (d >= `BIG_STEP) ? lg_tc : sm_tc;
      end
   endfunction

   // Offset and gain correction
   assign corrected = raw_sample_i - offset_err_i + gain_corr_i - zero_reg;
   assign delta = (corrected > filt_reg) ? corrected - filt_reg : filt_reg - corrected;
   assign shift = pick_tc(delta, tc_small_i, tc_large_i);
   assign mine = (req_addr_i == addr_reg);
   assign protected_cmd = (req_cmd_i == `CMD_ZERO_CLR) | (req_cmd_i == `CMD_RESTART) |
                          (req_cmd_i == `CMD_CFG_WR) | (req_cmd_i == `CMD_SPAN_TRIM) |
                          (req_cmd_i == `CMD_ZERO_TRIM);
   assign binary_mode_o = binary_reg;

   // Conversion tick, single-pole filter, newest result kept
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         conv_cnt_reg <= 32'h0000_0000;
         conv_start_o <= 1'b0;
         filt_reg     <= 16'h0000;
         result_o     <= 16'h0000;
      end else begin
         conv_start_o <= 1'b0;
         if (conv_cnt_reg == `CONV_CYCLES - 32'h0000_0001) begin
            conv_cnt_reg <= 32'h0000_0000;
            conv_start_o <= 1'b1;
            if (corrected > filt_reg)
               filt_reg <= filt_reg + (delta >> shift);
            else
               filt_reg <= filt_reg - (delta >> shift);
            result_o <= filt_reg; // Overwrites older result
         end else begin
            conv_cnt_reg <= conv_cnt_reg + 32'h0000_0001;
         end
      end
   end

   //-----------------------------------------
   // Command execution and reply
   //-----------------------------------------
   // Decode, execute, then send reply bytes one by one
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         addr_reg     <= `FACTORY_ADDR;
         cfg_reg      <= `FACTORY_CFG;
         binary_reg   <= 1'b0;
         wren_reg     <= 1'b0;
         zero_reg     <= 16'h0000;
         dout_o       <= {`DIO_W{1'b0}};
         restart_o    <= 1'b0;
         nv_write_o   <= 1'b0;
         nv_addr_o    <= 8'h00;
         nv_cfg_o     <= 16'h0000;
         state_reg    <= S_IDLE;
         byte_cnt_reg <= 3'h0;
         reply_reg    <= 40'h00_0000_0000;
         tx_byte_reg  <= 8'h00;
         send_reg     <= 1'b0;
      end else begin
         nv_write_o <= 1'b0;
         restart_o  <= 1'b0;
         send_reg   <= 1'b0;
         if (nv_valid_i && state_reg == S_IDLE) begin
            addr_reg   <= nv_addr_i; // Stored settings restored
            cfg_reg    <= nv_cfg_i;
            binary_reg <= nv_cfg_i[`CFG_MODE_BIT];
         end
         case (state_reg)
            S_IDLE: begin
               if (req_valid_i && mine && req_addr_i <= `ADDR_MAX) begin
                  state_reg    <= S_SEND;
                  byte_cnt_reg <= 3'h3;
                  if (req_binary_i && binary_reg) begin
                     case (req_func_i)
                        `FC_READ_DISC:   reply_reg <= {req_func_i, 2'b00, din_i, 24'h00_0000};
                        `FC_READ_INPUT:  reply_reg <= {req_func_i, result_o, 16'h0000};
                        `FC_FORCE_COIL:  begin
                           dout_o[req_arg_i[2:0]] <= req_arg_i[15];
                           reply_reg <= {req_func_i, req_arg_i, 16'h0000};
                        end
                        `FC_PRESET_REG:  begin
                           cfg_reg <= req_arg_i;
                           reply_reg <= {req_func_i, req_arg_i, 16'h0000};
                        end
                        `FC_FORCE_COILS: begin
                           dout_o <= req_arg_i[`DIO_W-1:0];
                           reply_reg <= {req_func_i, req_arg_i, 16'h0000};
                        end
                        default:         reply_reg <= {req_func_i | 8'h80, 32'h0100_0000};
                     endcase // Reply follows every request
                  end else if (!req_binary_i) begin
                     wren_reg <= (req_cmd_i == `CMD_WREN);
                     // Star-led text reply
                     reply_reg <= {8'h2A, 32'h0000_0000};
                     byte_cnt_reg <= 3'h0;
                     if (protected_cmd && !wren_reg) begin
                        state_reg <= S_IDLE; // Refused silently
                     end else begin
                        case (req_cmd_i)
                           `CMD_DISC:       begin
                              reply_reg <= {8'h2A, 2'b00, din_i, 24'h00_0000};
                              byte_cnt_reg <= 3'h1;
                           end
                           `CMD_OUT:        dout_o <= req_arg_i[`DIO_W-1:0];
                           `CMD_DATA:       begin
                              reply_reg <= {8'h2A, result_o, 16'h0000};
                              byte_cnt_reg <= 3'h2;
                           end
                           `CMD_CFG_RD, `CMD_CFG_RD_ALT: begin
                              reply_reg <= {8'h2A, cfg_reg, 16'h0000};
                              byte_cnt_reg <= 3'h2;
                           end
                           `CMD_ZERO_RD:    begin
                              reply_reg <= {8'h2A, zero_reg, 16'h0000};
                              byte_cnt_reg <= 3'h2;
                           end
                           `CMD_ZERO_CLR:   zero_reg <= 16'h0000;
                           `CMD_ZERO_TRIM:  zero_reg <= corrected - req_arg_i;
                           `CMD_SPAN_TRIM:  cfg_reg[7:0] <= req_arg_i[7:0];
                           `CMD_RESTART:    restart_o <= 1'b1;
                           `CMD_CFG_WR:     begin
                              cfg_reg    <= req_arg_i;
                              binary_reg <= req_arg_i[`CFG_MODE_BIT];
                              nv_write_o <= 1'b1;
                              nv_addr_o  <= addr_reg;
                              nv_cfg_o   <= req_arg_i;
                           end
                           default:         ;
                        endcase
                     end
                  end else begin
                     state_reg <= S_IDLE;
                  end
               end
            end
            S_SEND: begin
               if (!framer_busy) begin
                  tx_byte_reg <= reply_reg[39:32];
                  reply_reg   <= {reply_reg[31:0], 8'h00};
                  send_reg    <= 1'b1;
                  state_reg   <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (!framer_busy && !send_reg) begin
                  if (byte_cnt_reg == 3'h0) begin
                     state_reg <= S_IDLE;
                  end else begin
                     byte_cnt_reg <= byte_cnt_reg - 3'h1;
                     state_reg    <= S_SEND;
                  end
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   //-----------------------------------------
   // Line transmitter
   //-----------------------------------------
   line_framer u_framer (
      .clock_i   (clock_i),
      .resetn_i  (resetn_i),
      .rate_i    (cfg_reg[`CFG_RATE]),
      .parity_i  (cfg_reg[`CFG_PAR]),
      .send_i    (send_reg),
      .data_i    (tx_byte_reg),
      .busy_o    (framer_busy),
      .tx_o      (tx_o),
      .tx_oe_n_o (tx_oe_n_o)
   );
endmodule // sensor_cmd_handler
`default_nettype wire

// ---- common/sensor_cmd_map.vh ----
// What this block does
// - Convert eight per second, keep newest only
// - Data query answered at once from buffer
// - Act only on own programmable node address
// - One single-pole filter, time constant set by step size
// - Transmit only in reply to addressed request
// - Answer with data or acknowledge, except guarded text without write enable and binary in text mode
// - Accept read discrete and read input codes
// - Accept force coil, preset register, force coils
// - Text commands use prompt, address, mnemonic, star reply
// - Settings held in nonvolatile store
// - Start in text mode from manufacture
// - Offset and gain corrected continuously
// - Drive output switches, report digital inputs
// - Frame is start, eight data, parity or extra stop, stop
// - Rates 300 to 38400 in doubling steps
// - Parity odd, even or none on transmitted frames
`ifndef SENSOR_CMD_MAP_VH
`define SENSOR_CMD_MAP_VH
`define CLK_HZ          32'd200_000_000
`define CONV_PER_SEC    32'd8
`define CONV_CYCLES     (`CLK_HZ / `CONV_PER_SEC)
`define BASE_BAUD       32'd300
`define FC_READ_DISC    8'h01
`define FC_READ_INPUT   8'h04
`define FC_FORCE_COIL   8'h05
`define FC_PRESET_REG   8'h06
`define FC_FORCE_COILS  8'h0F
`define CMD_DISC        4'h1
`define CMD_OUT         4'h2
`define CMD_DATA        4'h3
`define CMD_CFG_RD      4'h4
`define CMD_CFG_RD_ALT  4'h5
`define CMD_ZERO_RD     4'h6
`define CMD_WREN        4'h7
`define CMD_ZERO_CLR    4'h8
`define CMD_RESTART     4'h9
`define CMD_CFG_WR      4'hA
`define CMD_SPAN_TRIM   4'hB
`define CMD_ZERO_TRIM   4'hC
`define PAR_NONE        2'h0
`define PAR_ODD         2'h1
`define PAR_EVEN        2'h2
`define RATE_MAX        3'h7
`define ADDR_MAX        8'hF7
`define FACTORY_ADDR    8'h01
`define FACTORY_CFG     16'h0000
`define SAMPLE_W        16
`define BIG_STEP        16'h0100
`define DIO_W           6
`define CFG_MODE_BIT    15
`define CFG_RATE        10:8
`define CFG_PAR         12:11
`define FRAME_BITS      4'hA
`endif

// ---- design/line_framer.v ----
`include "sensor_cmd_map.vh"
`default_nettype none
// Serial character sender: start, eight data, parity or extra stop, stop
module line_framer (
   input  wire       clock_i,
   input  wire       resetn_i,
   input  wire [2:0] rate_i,
   input  wire [1:0] parity_i,
   input  wire       send_i,
   input  wire [7:0] data_i,
   output wire       busy_o,
   output reg        tx_o,
   output reg        tx_oe_n_o
);
   reg  [31:0] div_reg;
   reg  [3:0]  bit_reg;
   reg  [10:0] shift_reg;
   reg         act_reg;
   wire [31:0] bit_cycles;
   wire        par_bit;
   wire        tick;

   // Bit period from selected rate, doubling steps
   assign bit_cycles = (`CLK_HZ / `BASE_BAUD) >> rate_i;
   assign tick       = (div_reg == 32'h0000_0000);
   assign par_bit    = (parity_i == `PAR_ODD) ? ~(^data_i) : (^data_i);
   assign busy_o     = act_reg | send_i;

   // Shift out one frame; driver enabled only during frame
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_reg   <= 32'h0000_0000;
         bit_reg   <= 4'h0;
         shift_reg <= 11'h7FF;
         act_reg   <= 1'b0;
         tx_o      <= 1'b1;
         tx_oe_n_o <= 1'b1;
      end else if (!act_reg) begin
         tx_o      <= 1'b1;
         tx_oe_n_o <= 1'b1;
         if (send_i) begin
            act_reg   <= 1'b1;
            div_reg   <= bit_cycles - 32'h0000_0001;
            // Stop, parity or extra stop, data LSB first, start
            shift_reg <= {1'b1, (parity_i == `PAR_NONE) ? 1'b1 : par_bit, data_i, 1'b0};
            bit_reg   <= `FRAME_BITS;
            tx_o      <= 1'b0;
            tx_oe_n_o <= 1'b0;
         end
      end else if (tick) begin
         div_reg <= bit_cycles - 32'h0000_0001;
         if (bit_reg == 4'h0) begin
            act_reg <= 1'b0;
         end else begin
            bit_reg   <= bit_reg - 4'h1;
            shift_reg <= {1'b1, shift_reg[10:1]};
            tx_o      <= shift_reg[1];
         end
      end else begin
         div_reg <= div_reg - 32'h0000_0001;
      end
   end
endmodule // line_framer
`default_nettype wire

// ---- verif/sensor_cmd_handler_asserts.sv ----
`include "sensor_cmd_map.vh"
`default_nettype none
// ----
// Port checker
// ----
module sensor_cmd_checker (
   input wire logic        clock_i,
   input wire logic        resetn_i,
   input wire logic        req_valid_i,
   input wire logic        req_binary_i,
   input wire logic [7:0]  req_addr_i,
   input wire logic [7:0]  req_func_i,
   input wire logic [3:0]  req_cmd_i,
   input wire logic [7:0]  nv_addr_i,
   input wire logic [15:0] nv_cfg_i,
   input wire logic        nv_valid_i,
   input wire logic        nv_write_o,
   input wire logic        binary_mode_o,
   input wire logic        conv_start_o,
   input wire logic        restart_o,
   input wire logic        tx_o,
   input wire logic        tx_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] own_reg;
   logic [1:0] gap_reg;
   logic       we_reg;
   logic       load_reg;
   wire        fresh = req_valid_i && gap_reg == 2'h0 && tx_oe_n_o;
   wire        query = fresh && req_addr_i == own_reg && (req_binary_i ?
      (binary_mode_o && req_func_i == `FC_READ_INPUT) : (!binary_mode_o && req_cmd_i == `CMD_DATA));
   wire        guard = fresh && !req_binary_i && !binary_mode_o && !we_reg &&
      req_cmd_i >= `CMD_ZERO_CLR && req_cmd_i <= `CMD_ZERO_TRIM;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   // Own address, request spacing, write-enable memory
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         own_reg  <= `FACTORY_ADDR;
         gap_reg  <= 2'h0;
         we_reg   <= 1'b0;
         load_reg <= 1'b0;
      end else begin
         if (nv_valid_i) begin
            own_reg  <= nv_addr_i;
            load_reg <= 1'b1;
         end
         if (req_valid_i) begin
            gap_reg <= 2'h3;
            we_reg  <= !req_binary_i && req_cmd_i == `CMD_WREN;
         end else if (gap_reg != 2'h0) begin
            gap_reg <= gap_reg - 2'h1;
         end
      end
   end
   // Reply start and silent line shapes
   sequence s_quiet;
      tx_oe_n_o [*3];
   endsequence
   sequence s_reply;
      tx_oe_n_o [*2] ##[1:2] (!tx_oe_n_o && !tx_o);
   endsequence
   a_query_reply: assert property (query |-> s_reply)
      else $error("query reply late");
   a_query_no_conv: assert property (query |-> !conv_start_o [*3])
      else $error("query started conversion");
   a_other_addr: assert property (fresh && req_addr_i != own_reg |-> s_quiet)
      else $error("foreign address answered");
   a_binary_refused: assert property (fresh && req_binary_i && !binary_mode_o |-> s_quiet)
      else $error("binary answered in text mode");
   a_protect_guard: assert property (guard |-> (!restart_o && !nv_write_o && tx_oe_n_o) [*4])
      else $error("guarded command acted");
   a_start_bit: assert property ($fell(tx_oe_n_o) |-> (!tx_o && !tx_oe_n_o) [*8])
      else $error("start bit wrong");
   a_idle_mark: assert property (tx_oe_n_o |-> tx_o)
      else $error("idle line not high");
   a_factory_text: assert property (!load_reg |-> !binary_mode_o)
      else $error("not in text mode");
   a_store_mode: assert property (nv_valid_i |=> binary_mode_o == $past(nv_cfg_i[15]))
      else $error("stored mode not applied");
endmodule // sensor_cmd_checker
bind sensor_cmd_handler sensor_cmd_checker u_sensor_cmd_checker (.clock_i(clock_i), .resetn_i(resetn_i),
   .req_valid_i(req_valid_i), .req_binary_i(req_binary_i), .req_addr_i(req_addr_i), .req_func_i(req_func_i),
   .req_cmd_i(req_cmd_i), .nv_addr_i(nv_addr_i), .nv_cfg_i(nv_cfg_i), .nv_valid_i(nv_valid_i),
   .nv_write_o(nv_write_o), .binary_mode_o(binary_mode_o), .conv_start_o(conv_start_o),
   .restart_o(restart_o), .tx_o(tx_o), .tx_oe_n_o(tx_oe_n_o));
`default_nettype wire

// ---- verif/host_line_model.sv ----
`default_nettype none
// ----
// Host receiver
// ----
module host_line_model #(
   parameter int BIT_CYCLES = 5208 // Bit time at the fastest rate
) (
   input wire logic       clock_i,
   input wire logic       tx_o,
   input wire logic       tx_oe_n_o,
   output var logic [7:0] byte_o,
   output var logic       got_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire line = tx_oe_n_o ? 1'b1 : tx_o; // Released bus biased to mark
   // Catch start bit, then eight data bits LSB first
   initial begin
      got_o = 1'b0;
      byte_o = 8'h00;
      forever begin
         @(negedge line);
         repeat (BIT_CYCLES / 2) @(posedge clock_i);
         if (!line) begin
            got_o = 1'b0; // New frame, earlier catch no longer valid
            for (int k = 0; k < 8; k++) begin
               repeat (BIT_CYCLES) @(posedge clock_i);
               byte_o[k] = line;
            end
            got_o = 1'b1;
         end
      end
   end
endmodule // host_line_model
`default_nettype wire

// ---- verif/sensor_cmd_handler_tb.sv ----
`include "sensor_cmd_map.vh"
`default_nettype none
// ----
// Handler bench
// ----
module sensor_cmd_handler_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BITC = (200_000_000 / 300) >> 7;
   logic              clock_i, resetn_i, req_valid_i, req_binary_i, nv_valid_i, rep, side, got;
   logic [7:0]        req_addr_i, req_func_i, nv_addr_i, rx_byte, oth, nv_addr_o;
   logic [3:0]        req_cmd_i, tc_small_i, tc_large_i;
   logic [15:0]       req_arg_i, raw_sample_i, offset_err_i, gain_corr_i, nv_cfg_i, nv_cfg_o, rarg;
   logic [`DIO_W-1:0] din_i, dout_o;
   logic              nv_write_o, binary_mode_o, conv_start_o, restart_o, tx_o, tx_oe_n_o;
   logic [31:0]       rng = 32'h0000_d4b9;
   int                err_count = 0, n_checks = 0, k, own;
   int                guarded[$] = '{`CMD_ZERO_CLR, `CMD_RESTART, `CMD_CFG_WR, `CMD_SPAN_TRIM, `CMD_ZERO_TRIM};
   int                funcs[$] = '{`FC_READ_DISC, `FC_READ_INPUT, `FC_FORCE_COIL, `FC_PRESET_REG, `FC_FORCE_COILS};
   sensor_cmd_handler u_sensor_cmd_handler (.clock_i, .resetn_i, .req_valid_i, .req_binary_i, .req_addr_i,
      .req_func_i, .req_cmd_i, .req_arg_i, .raw_sample_i, .offset_err_i, .gain_corr_i, .din_i, .tc_small_i,
      .tc_large_i, .nv_addr_i, .nv_cfg_i, .nv_valid_i, .nv_write_o, .nv_addr_o, .nv_cfg_o, .binary_mode_o,
      .conv_start_o, .result_o(), .dout_o, .restart_o, .tx_o, .tx_oe_n_o);
   host_line_model #(.BIT_CYCLES(BITC)) u_host_line_model (.clock_i, .tx_o, .tx_oe_n_o, .byte_o(rx_byte),
      .got_o(got));
   always #2.5 clock_i = ~clock_i;
   // Helpers: random source, model, compares, drivers
   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic logic text_ok(int c);
      foreach (guarded[i]) if (guarded[i] == c) return 1'b0;
      return 1'b1;
   endfunction
   task automatic chk_bit(input logic got_v, input logic exp_v, input string what);
      n_checks++;
      if (got_v !== exp_v) begin
         err_count++;
         $display("Error t=%0t %s", $time, what);
      end
   endtask
   task automatic chk_val(input logic [7:0] got_v, input logic [7:0] exp_v, input string what);
      n_checks++;
      if (got_v !== exp_v) begin
         err_count++;
         $display("Error t=%0t %s got %h exp %h", $time, what, got_v, exp_v);
      end
   endtask
   task automatic boot(input logic [7:0] a, input logic [15:0] cfg, input logic load);
      resetn_i = 1'b0;
      repeat (4) @(posedge clock_i);
      #1 resetn_i = 1'b1;
      if (load) begin
         @(posedge clock_i);
         #1 {nv_addr_i, nv_cfg_i, nv_valid_i} = {a, cfg, 1'b1};
         @(posedge clock_i);
         #1 nv_valid_i = 1'b0;
      end
   endtask
   task automatic send(input logic b, input logic [7:0] a, input logic [7:0] f, input logic [3:0] c,
                       input logic [15:0] arg);
      @(posedge clock_i);
      #1 {req_binary_i, req_addr_i, req_func_i, req_cmd_i, req_arg_i, req_valid_i} = {b, a, f, c, arg, 1'b1};
      @(posedge clock_i);
      #1 {req_valid_i, rep, side} = 3'b000;
      repeat (8) begin
         if (!tx_oe_n_o) rep = 1'b1;
         if (restart_o || nv_write_o) side = 1'b1;
         @(posedge clock_i);
         #1;
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #(BITC * 80);
      err_count++;
      close_out();
   end
   // Main sequence
   initial begin
      {clock_i, resetn_i, req_valid_i, req_binary_i, nv_valid_i, req_addr_i, req_func_i, req_cmd_i} = '0;
      {req_arg_i, nv_addr_i, nv_cfg_i} = '0;
      {raw_sample_i, offset_err_i} = rnd();
      gain_corr_i = 16'(rnd());
      din_i = 6'(rnd());
      tc_small_i = 4'hC; // Long constant for small steps
      tc_large_i = 4'h2; // Short constant for large steps
      for (k = 1; k <= 12; k++) begin
         boot(8'h01, 16'h0000, 1'b0);
         chk_bit(binary_mode_o, 1'b0, "factory mode");
         rarg = 16'(rnd());
         send(1'b0, 8'h01, 8'h00, k[3:0], rarg);
         chk_bit(rep, text_ok(k), "text reply");
         chk_bit(side, 1'b0, "guarded side effect");
         if (k == `CMD_OUT) chk_val({2'b00, dout_o}, {2'b00, rarg[5:0]}, "text outputs");
      end
      send(1'b1, 8'h01, `FC_READ_INPUT, 4'h0, 16'h0000);
      chk_bit(rep, 1'b0, "binary in text mode");
      $display("text commands done");
      foreach (funcs[i]) begin
         own = 1 + rnd() % 247;
         k = rnd() % 6;
         boot(own[7:0], 16'h8000, 1'b1);
         chk_bit(binary_mode_o, 1'b1, "stored mode");
         send(1'b1, own[7:0], funcs[i][7:0], 4'h0, {1'b1, 12'h000, k[2:0]});
         chk_bit(rep, 1'b1, "binary reply");
         if (funcs[i] == `FC_FORCE_COIL) chk_val({2'b00, dout_o}, 8'h01 << k, "coil");
      end
      $display("binary functions done");
      own = 1 + rnd() % 247;
      oth = (own == 247) ? 8'h01 : own[7:0] + 8'h01;
      boot(own[7:0], 16'h8000, 1'b1);
      send(1'b1, oth, `FC_READ_INPUT, 4'h0, 16'h0000);
      chk_bit(rep, 1'b0, "foreign address");
      send(1'b1, own[7:0], `FC_READ_INPUT, 4'h0, 16'h0000);
      chk_bit(rep, 1'b1, "own address");
      $display("addressing done");
      boot(8'h01, 16'h0700, 1'b1);
      send(1'b0, 8'h01, 8'h00, `CMD_DATA, 16'h0000);
      chk_bit(rep, 1'b1, "data query");
      // Fresh boot, then one quiet bit so the host model waits for a clean start
      boot(8'h01, 16'h0700, 1'b1);
      repeat (BITC) @(posedge clock_i);
      send(1'b0, 8'h01, 8'h00, `CMD_WREN, 16'h0000);
      chk_bit(rep, 1'b1, "write enable reply");
      for (k = 0; k < 11 * BITC && !got; k++) @(posedge clock_i);
      chk_val(rx_byte, 8'h2A, "reply lead byte");
      for (k = 0; k < 4 * BITC && !tx_oe_n_o; k++) @(posedge clock_i);
      #1;
      chk_bit(tx_oe_n_o, 1'b1, "line released");
      send(1'b0, 8'h01, 8'h00, `CMD_CFG_WR, 16'h0700);
      chk_bit(rep, 1'b1, "enabled write reply");
      chk_bit(side, 1'b1, "enabled write stored");
      chk_val(nv_addr_o, 8'h01, "stored address");
      chk_val(nv_cfg_o[15:8], 8'h07, "stored setup high");
      chk_val(nv_cfg_o[7:0], 8'h00, "stored setup low");
      $display("frame decode done");
      close_out();
   end
endmodule // sensor_cmd_handler_tb
`default_nettype wire
